// >>> design/tap_edge_sync.sv
`timescale 1ns/1ps
module tap_edge_sync
  import tap_decode_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  logic meta;
  logic sync;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= i_pin;
      sync <= meta;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_level <= 1'b0;
      o_rise  <= 1'b0;
      o_fall  <= 1'b0;
    end else begin
      o_level <= sync;
      o_rise  <= sync & ~o_level;
      o_fall  <= ~sync & o_level;
    end
  end
endmodule : tap_edge_sync

// >>> design/tap_instruction_decoder.sv
`timescale 1ns/1ps
module tap_instruction_decoder
  import tap_decode_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_resetn,
  tap_link_if.device                link,
  input  wire logic [BSR_WIDTH-1:0] i_ball_levels,
  output logic [BSR_WIDTH-1:0]      o_ball_values,
  output logic [1:0]                o_ball_mode,
  output logic [IR_WIDTH-1:0]       o_instruction,
  output logic                      o_test_reset
);
  logic          tck_rise;
  logic          tck_fall;
  logic          tms;
  logic          tdi;
  tap_state_type state;
  logic [IR_WIDTH-1:0]  ir_shift;
  logic [IR_WIDTH-1:0]  ir;
  logic [ID_WIDTH-1:0]  id_shift;
  logic [BSR_WIDTH-1:0] bsr_shift;
  logic [BSR_WIDTH-1:0] bsr_hold;
  logic                 bypass_bit;
  path_type             path;
  balls_type            balls;
  logic                 serial_out;
  logic                 tdo;
  logic                 tdo_enable;
  logic [BSR_WIDTH-1:0] ball_meta;
  logic [BSR_WIDTH-1:0] ball_sync;

  ////////////////////////////////////////////////////////////////////////////////
  tap_edge_sync u_tck (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_pin    (link.tck),
    .o_level  (),
    .o_rise   (tck_rise),
    .o_fall   (tck_fall)
  );

  tap_edge_sync u_tms (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_pin    (link.tms),
    .o_level  (tms),
    .o_rise   (),
    .o_fall   ()
  );

  tap_edge_sync u_tdi (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_pin    (link.tdi),
    .o_level  (tdi),
    .o_rise   (),
    .o_fall   ()
  );

  // two flops before the captured ball levels
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ball_meta <= '0;
      ball_sync <= '0;
    end else begin
      ball_meta <= i_ball_levels;
      ball_sync <= ball_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // standard sequencing
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= TLR;
    end else if (tck_rise) begin
      state <= next_tap(state, tms);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ir_shift <= CODE_IDCODE;
    end else if (tck_rise) begin
      case (state)
        CAP_IR: ir_shift <= {ir[IR_WIDTH-1:2], CAPTURE_IR_PATTERN};
        SH_IR:  ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]};
        default: ir_shift <= ir_shift;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ir <= CODE_IDCODE;
    end else if (tck_rise) begin
      if (next_tap(state, tms) == TLR) begin
        ir <= CODE_IDCODE;
      end else if (state == UPD_IR) begin
        ir <= ir_shift;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode the five codes; every other code, bypass included, selects bypass
  always_comb begin
    case (ir)
      CODE_EXTEST: begin
        path  = PATH_BSR;
        balls = BALLS_BSR;
      end
      CODE_IDCODE: begin
        path  = PATH_ID;
        balls = BALLS_NORMAL;
      end
      CODE_SAMPLE: begin
        path  = PATH_BSR;
        balls = BALLS_NORMAL;
      end
      CODE_CLAMP: begin
        path  = PATH_BYPASS;
        balls = BALLS_BSR;
      end
      CODE_HIGHZ: begin
        path  = PATH_BYPASS;
        balls = BALLS_HIGHZ;
      end
      default: begin
        path  = PATH_BYPASS;
        balls = BALLS_NORMAL;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      id_shift   <= '0;
      bsr_shift  <= '0;
      bypass_bit <= 1'b0;
    end else if (tck_rise) begin
      if (state == CAP_DR) begin
        id_shift   <= ID_VALUE;
        bypass_bit <= 1'b0;
        if (path == PATH_BSR) begin
          bsr_shift <= ball_sync;
        end
      end else if (state == SH_DR) begin
        id_shift   <= {tdi, id_shift[ID_WIDTH-1:1]};
        bypass_bit <= tdi;
        if (path == PATH_BSR) begin
          bsr_shift <= {tdi, bsr_shift[BSR_WIDTH-1:1]};
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bsr_hold <= '0;
    end else if (tck_rise && state == UPD_DR && path == PATH_BSR) begin
      bsr_hold <= bsr_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (state == SH_IR) begin
      serial_out = ir_shift[0];
    end else begin
      case (path)
        PATH_BSR: serial_out = bsr_shift[0];
        PATH_ID:  serial_out = id_shift[0];
        default:  serial_out = bypass_bit;
      endcase
    end
  end

  // output changes on every falling test clock; enable set only in shift states
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tdo        <= 1'b0;
      tdo_enable <= 1'b0;
    end else if (tck_fall) begin
      tdo        <= serial_out;
      tdo_enable <= (state == SH_IR) || (state == SH_DR);
    end
  end

  assign link.tdo        = tdo;
  assign link.tdo_enable = tdo_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // drive preloaded values
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ball_values <= '0;
      o_ball_mode   <= BALLS_NORMAL;
      o_instruction <= CODE_IDCODE;
      o_test_reset  <= 1'b1;
    end else begin
      o_ball_values <= bsr_hold;
      o_ball_mode   <= balls;
      o_instruction <= ir;
      o_test_reset  <= (state == TLR);
    end
  end
endmodule : tap_instruction_decoder

// >>> design/tap_test_controller.sv
`timescale 1ns/1ps
module tap_test_controller
  import tap_decode_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  tap_link_if.controller   link,
  input  wire logic        i_start,
  input  wire logic        i_is_ir,
  input  wire logic [7:0]  i_length,
  input  wire logic [127:0] i_data,
  output logic             o_busy,
  output logic             o_done,
  output logic [127:0]     o_data
);
  typedef enum logic [4:0] {
    C_IDLE = 5'h01, C_RESET = 5'h02, C_HEAD = 5'h04, C_SHIFT = 5'h08, C_TAIL = 5'h10
  } ctl_type;

  ctl_type      cstate;
  logic [2:0]   div;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic [7:0]   count;
  logic [7:0]   length;
  logic [127:0] shreg;
  logic [127:0] capture;
  logic         tdo_meta;
  logic         tdo_sync;
  logic         ir_scan;
  logic [3:0]   head_bits;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tdo_meta <= 1'b0;
      tdo_sync <= 1'b0;
    end else begin
      tdo_meta <= link.tdo;
      tdo_sync <= tdo_meta;
    end
  end

  // slow divided clock
  // divided test clock; tms/tdi change on the fall so the device sees them stable
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      div <= '0;
      tck <= 1'b0;
    end else begin
      div <= div + 3'h1;
      if (div == 3'(LINK_DIVIDE / 2 - 1)) begin
        tck <= ~tck;
      end
    end
  end

  logic step;
  assign step = (div == 3'(LINK_DIVIDE / 2 - 1)) && tck;

  // caller-supplied codes are sent as given, with no legality check
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cstate  <= C_RESET;
      count   <= 8'h00;
      tms     <= 1'b1;
      tdi     <= 1'b0;
      length  <= 8'h00;
      shreg   <= '0;
      capture <= '0;
      ir_scan <= 1'b0;
      o_busy  <= 1'b1;
      o_done  <= 1'b0;
      o_data  <= '0;
      head_bits <= 4'h0;
    end else begin
      o_done <= 1'b0;
      case (cstate)
        C_IDLE: begin
          tms <= 1'b0;
          if (i_start) begin
            cstate  <= C_HEAD;
            ir_scan <= i_is_ir;
            length  <= i_length;
            shreg   <= i_data;
            count   <= 8'h00;
            o_busy  <= 1'b1;
            head_bits <= i_is_ir ? 4'h3 : 4'h2;
          end
        end
        C_RESET: if (step) begin
          tms   <= (count < 8'(RESET_TMS_EDGES));
          count <= count + 8'h01;
          if (count == 8'(RESET_TMS_EDGES)) begin
            cstate <= C_IDLE;
            o_busy <= 1'b0;
          end
        end
        C_HEAD: if (step) begin
          // rti -> sel_dr (-> sel_ir) -> capture -> shift
          tms   <= (count < 8'(head_bits) - 8'h01);
          if (count == 8'(head_bits)) begin
            tms    <= 1'b0;
            count  <= 8'h00;
            cstate <= C_SHIFT;
          end else begin
            count <= count + 8'h01;
          end
        end
        C_SHIFT: if (step) begin
          tdi   <= shreg[0];
          shreg <= {1'b0, shreg[127:1]};
          // high with the last bit (to exit1) and once more (to update)
          tms   <= (count >= length - 8'h01);
          if (count != 8'h00) begin
            capture <= {tdo_sync, capture[127:1]};
          end
          count <= count + 8'h01;
          if (count == length) begin
            cstate <= C_TAIL;
            count  <= 8'h00;
          end
        end
        C_TAIL: if (step) begin
          tms   <= 1'b0;
          count <= count + 8'h01;
          if (count == 8'h01) begin
            cstate <= C_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_data <= capture >> (8'd128 - length);
          end
        end
        default: cstate <= C_RESET;
      endcase
    end
  end

  assign link.tck = tck;
  assign link.tms = tms;
  assign link.tdi = tdi;
endmodule : tap_test_controller

// >>> include/tap_decode_pkg.sv
package tap_decode_pkg;
  localparam int IR_WIDTH            = 8;
  localparam int ID_WIDTH            = 32;
  localparam int BSR_WIDTH           = 113;
  localparam int RESET_TMS_EDGES     = 5;
  localparam int LINK_DIVIDE         = 8;
  localparam logic [7:0] CODE_EXTEST  = 8'h00;
  localparam logic [7:0] CODE_IDCODE  = 8'h21;
  localparam logic [7:0] CODE_SAMPLE  = 8'h05;
  localparam logic [7:0] CODE_CLAMP   = 8'h07;
  localparam logic [7:0] CODE_HIGHZ   = 8'h03;
  localparam logic [7:0] CODE_BYPASS  = 8'hff;
  localparam logic [1:0] CAPTURE_IR_PATTERN = 2'h1;
  // arbitrary neutral identification value
  localparam logic [31:0] ID_VALUE    = 32'h10000001;

  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
    SH_DR = 16'h0010, EX1_DR = 16'h0020, PA_DR = 16'h0040, EX2_DR = 16'h0080,
    UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
    EX1_IR = 16'h1000, PA_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
  } tap_state_type;

  typedef enum logic [2:0] {
    PATH_BYPASS = 3'h0, PATH_BSR = 3'h1, PATH_ID = 3'h2
  } path_type;

  typedef enum logic [1:0] {
    BALLS_NORMAL = 2'h0, BALLS_BSR = 2'h1, BALLS_HIGHZ = 2'h2
  } balls_type;

  function automatic tap_state_type next_tap(input tap_state_type s, input logic tms);
    case (s)
      TLR:     next_tap = tms ? TLR : RTI;
      RTI:     next_tap = tms ? SEL_DR : RTI;
      SEL_DR:  next_tap = tms ? SEL_IR : CAP_DR;
      CAP_DR:  next_tap = tms ? EX1_DR : SH_DR;
      SH_DR:   next_tap = tms ? EX1_DR : SH_DR;
      EX1_DR:  next_tap = tms ? UPD_DR : PA_DR;
      PA_DR:   next_tap = tms ? EX2_DR : PA_DR;
      EX2_DR:  next_tap = tms ? UPD_DR : SH_DR;
      UPD_DR:  next_tap = tms ? SEL_DR : RTI;
      SEL_IR:  next_tap = tms ? TLR : CAP_IR;
      CAP_IR:  next_tap = tms ? EX1_IR : SH_IR;
      SH_IR:   next_tap = tms ? EX1_IR : SH_IR;
      EX1_IR:  next_tap = tms ? UPD_IR : PA_IR;
      PA_IR:   next_tap = tms ? EX2_IR : PA_IR;
      EX2_IR:  next_tap = tms ? UPD_IR : SH_IR;
      UPD_IR:  next_tap = tms ? SEL_DR : RTI;
      default: next_tap = TLR;
    endcase
  endfunction : next_tap
endpackage : tap_decode_pkg

// >>> include/tap_link_if.sv
`timescale 1ns/1ps
interface tap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_enable;
  modport device (input tck, input tms, input tdi, output tdo, output tdo_enable);
  modport controller (output tck, output tms, output tdi, input tdo, input tdo_enable);
endinterface : tap_link_if

// >>> sim/tap_link_checker.sv
`timescale 1ns/1ps
module tap_link_checker
  import tap_decode_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_enable
);
  logic          tck_q;
  logic          rise;
  logic          byp;
  tap_state_type st;
  logic [7:0]    ir_sh;
  logic [7:0]    ir_h;
  logic [7:0]    cur;
  logic [7:0]    ir_n;
  logic [7:0]    dr_n;
  logic [127:0]  dr_h;
  assign rise = tck & ~tck_q;
  assign byp = !(cur inside {CODE_EXTEST, CODE_SAMPLE, CODE_IDCODE});
  ////////////////////////////////////////
  // state followed from the wire
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tck_q <= 1'b0;
      st <= TLR;
    end else begin
      tck_q <= tck;
      if (rise) st <= next_tap(st, tms);
    end
  end
  // instruction in force
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cur <= CODE_IDCODE;
      ir_sh <= 8'h00;
    end else if (rise) begin
      if (next_tap(st, tms) == TLR) cur <= CODE_IDCODE;
      if (st == UPD_IR) cur <= ir_sh;
      if (st == CAP_IR) ir_sh <= {ir_sh[7:2], 2'h1};
      if (st == SH_IR) ir_sh <= {tdi, ir_sh[7:1]};
    end
  end
  // bit counts and shifted-in history
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ir_n <= 8'h00;
      dr_n <= 8'h00;
      ir_h <= 8'h00;
      dr_h <= '0;
    end else if (rise) begin
      if (st == CAP_IR) ir_n <= 8'h00;
      if (st == CAP_DR) dr_n <= 8'h00;
      if (st == SH_IR) ir_n <= ir_n + 8'h01;
      if (st == SH_DR) dr_n <= dr_n + 8'h01;
      if (st == SH_IR) ir_h <= {tdi, ir_h[7:1]};
      if (st == SH_DR) dr_h <= {dr_h[126:0], tdi};
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  property p_enable_in_shift;
    rise |-> tdo_enable == (st == SH_IR || st == SH_DR);
  endproperty
  a_enable_in_shift: assert property (p_enable_in_shift)
    else $error("tdo enable outside shift");
  property p_tdo_holds_high;
    rise && tdo_enable |=> $stable(tdo) [*2];
  endproperty
  a_tdo_holds_high: assert property (p_tdo_holds_high)
    else $error("tdo moved while tck high");
  property p_capture_pattern;
    rise && st == SH_IR && ir_n < 8'h02 |-> tdo == (ir_n == 8'h00);
  endproperty
  a_capture_pattern: assert property (p_capture_pattern)
    else $error("capture pattern wrong");
  property p_ir_through;
    rise && st == SH_IR && ir_n >= 8'h08 |-> tdo == ir_h[0];
  endproperty
  a_ir_through: assert property (p_ir_through)
    else $error("instruction path not eight bits");
  property p_id_out;
    rise && st == SH_DR && cur == CODE_IDCODE && dr_n < 8'h20 |-> tdo == ID_VALUE[dr_n[4:0]];
  endproperty
  a_id_out: assert property (p_id_out)
    else $error("identification bit wrong");
  property p_bypass_cleared;
    rise && st == SH_DR && byp && dr_n == 8'h00 |-> !tdo;
  endproperty
  a_bypass_cleared: assert property (p_bypass_cleared)
    else $error("bypass bit not cleared");
  property p_bypass_one_bit;
    rise && st == SH_DR && byp && dr_n != 8'h00 |-> tdo == dr_h[0];
  endproperty
  a_bypass_one_bit: assert property (p_bypass_one_bit)
    else $error("bypass path not one bit");
  property p_boundary_len;
    rise && st == SH_DR && !byp && cur != CODE_IDCODE && dr_n >= 8'h71
      |-> tdo == dr_h[BSR_WIDTH-1];
  endproperty
  a_boundary_len: assert property (p_boundary_len)
    else $error("boundary path length wrong");
  c_id: cover property (rise && st == SH_DR && cur == CODE_IDCODE && dr_n == 8'h1f);
  c_boundary: cover property (rise && st == SH_DR && dr_n == 8'h78);
  c_ir_long: cover property (rise && st == SH_IR && ir_n == 8'h0f);
endmodule : tap_link_checker

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb
  import tap_decode_pkg::*;
;
  logic                 i_clock;
  logic                 i_resetn;
  logic                 start;
  logic                 is_ir;
  logic [7:0]           len;
  logic [127:0]         din;
  logic                 busy;
  logic                 done;
  logic [127:0]         dout;
  logic [BSR_WIDTH-1:0] levels;
  logic [BSR_WIDTH-1:0] balls;
  logic [BSR_WIDTH-1:0] exp_balls;
  logic [1:0]           mode;
  logic [1:0]           mode2;
  logic [7:0]           instr;
  logic [7:0]           instr2;
  logic                 treset2;
  logic [7:0]           cur_code;
  logic [31:0]          seed;
  int                   errors;
  int                   check_count;
  tap_link_if link ();
  tap_link_if link2 ();
  tap_test_controller i_tap_test_controller (.i_clock(i_clock), .i_resetn(i_resetn),
    .link(link), .i_start(start), .i_is_ir(is_ir), .i_length(len), .i_data(din),
    .o_busy(busy), .o_done(done), .o_data(dout));
  tap_instruction_decoder i_tap_instruction_decoder (.i_clock(i_clock), .i_resetn(i_resetn),
    .link(link), .i_ball_levels(levels), .o_ball_values(balls), .o_ball_mode(mode),
    .o_instruction(instr), .o_test_reset());
  // second end driven by the bench, free to load reserved codes
  tap_instruction_decoder i_tap_instruction_decoder_2 (.i_clock(i_clock),
    .i_resetn(i_resetn), .link(link2), .i_ball_levels(levels), .o_ball_values(),
    .o_ball_mode(mode2), .o_instruction(instr2), .o_test_reset(treset2));
  tap_link_checker i_tap_link_checker (.i_clock(i_clock), .i_resetn(i_resetn),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo),
    .tdo_enable(link.tdo_enable));
  initial i_clock = 1'b0;
  always #2 i_clock = ~i_clock;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [127:0] mask(input logic [7:0] n);
    return (128'h1 << n) - 128'h1;
  endfunction : mask
  function automatic logic [7:0] path_len(input logic [7:0] c);
    if (c == CODE_IDCODE) return 8'h20;
    if (c == CODE_EXTEST || c == CODE_SAMPLE) return 8'h71;
    return 8'h01;
  endfunction : path_len
  function automatic logic [1:0] exp_mode(input logic [7:0] c);
    if (c == CODE_EXTEST || c == CODE_CLAMP) return BALLS_BSR;
    return (c == CODE_HIGHZ) ? BALLS_HIGHZ : BALLS_NORMAL;
  endfunction : exp_mode
  // captured bits first, then the bits shifted in
  function automatic logic [127:0] exp_dr(input logic [7:0] c, input logic [127:0] d);
    logic [127:0] cap;
    logic [7:0]   p;
    p = path_len(c);
    cap = (p == 8'h20) ? 128'(ID_VALUE) : (p == 8'h01) ? 128'h0 : 128'(levels);
    return ((cap & mask(p)) | (d << p)) & mask(p + 8'h08);
  endfunction : exp_dr
  ////////////////////////////////////////
  task automatic check(input logic [127:0] seen, input logic [127:0] expected);
    check_count++;
    if (seen !== expected) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic wait_for(input logic want_done);
    int n;
    n = 0;
    while ((want_done ? done : ~busy) !== 1'b1) begin
      @(posedge i_clock);
      n++;
      if (n > 4000) begin
        errors++;
        print_verdict();
      end
    end
  endtask : wait_for
  task automatic scan(input logic ir, input logic [7:0] n, input logic [127:0] d);
    wait_for(1'b0);
    start <= 1'b1;
    is_ir <= ir;
    len <= n;
    din <= d;
    @(posedge i_clock);
    start <= 1'b0;
    repeat (60) @(posedge i_clock);
    if (ir) check(instr, cur_code);
    wait_for(1'b1);
  endtask : scan
  // one bench-made tck period of 64 ns
  task automatic jbit(input logic tms, input logic tdi);
    link2.tck <= 1'b0;
    link2.tms <= tms;
    link2.tdi <= tdi;
    repeat (8) @(posedge i_clock);
    link2.tck <= 1'b1;
    repeat (8) @(posedge i_clock);
  endtask : jbit
  ////////////////////////////////////////
  initial begin
    logic [7:0]   codes [6];
    logic [7:0]   code;
    logic [31:0]  r;
    logic [127:0] d;
    codes = '{CODE_SAMPLE, CODE_EXTEST, CODE_IDCODE, CODE_CLAMP, CODE_HIGHZ, CODE_BYPASS};
    errors = 0;
    check_count = 0;
    seed = 32'h6b45;
    i_resetn = 1'b0;
    start = 1'b0;
    is_ir = 1'b0;
    len = 8'h00;
    din = '0;
    levels = '0;
    link2.tck = 1'b0;
    link2.tms = 1'b1;
    link2.tdi = 1'b0;
    cur_code = CODE_IDCODE;
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    check(instr, CODE_IDCODE);
    // preload before extest
    // sample first so extest drives the preloaded vector
    for (int k = 0; k < 8; k++) begin
      repeat (32) seed = lfsr(seed);
      r = seed;
      // only implemented codes on the main link
      code = (k < 6) ? codes[k] : codes[r[7:0] % 8'd6];
      scan(1'b1, 8'h10, {112'h0, code, r[7:0]});
      cur_code = code;
      check(dout[1:0], 2'h1);
      check(dout[15:8], r[7:0]);
      check(instr, code);
      check(mode, exp_mode(code));
      if (k > 0) check(balls, exp_balls);
      for (int j = 0; j < 4; j++) begin
        repeat (32) seed = lfsr(seed);
        d = {d[95:0], seed};
      end
      levels <= {d[63:0], d[127:79]};
      scan(1'b0, path_len(code) + 8'h08, d);
      check(dout & mask(path_len(code) + 8'h08), exp_dr(code, d));
      if (path_len(code) == 8'h71) exp_balls = d[8 +: BSR_WIDTH];
      check(balls, exp_balls);
    end
    // reserved code loaded by hand on the second link
    code = {2'h2, r[13:8]};
    repeat (5) jbit(1'b1, 1'b0);
    jbit(1'b0, 1'b0);
    jbit(1'b1, 1'b0);
    jbit(1'b1, 1'b0);
    jbit(1'b0, 1'b0);
    jbit(1'b0, 1'b0);
    for (int k = 0; k < 8; k++) jbit(k == 7, code[k]);
    jbit(1'b1, 1'b0);
    jbit(1'b0, 1'b0);
    check(instr2, code);
    check(mode2, BALLS_NORMAL);
    jbit(1'b1, 1'b0);
    jbit(1'b0, 1'b0);
    jbit(1'b0, 1'b0);
    repeat (4) jbit(1'b1, 1'b0);
    check(treset2, 1'b0);
    jbit(1'b1, 1'b0);
    check(treset2, 1'b1);
    check(instr2, CODE_IDCODE);
    print_verdict();
  end
endmodule : tb
